//--- common/ercd_pkg.sv
// constants and carrier types for the escaped register command decoder
package ercd_pkg;
  // framing byte values
  localparam logic [7:0] HDR_BYTE = 8'hff;
  localparam logic [7:0] ESC_BYTE = 8'hfe;
  localparam logic [7:0] ACK_BYTE = 8'h06;
  localparam logic [7:0] NACK_BYTE = 8'h15;
  localparam logic [7:0] RSV_LOW = 8'hf0;
  localparam logic [7:0] LIT_MAX = 8'hef;
  localparam logic [7:0] BIT7_MASK = 8'h80;
  localparam logic [7:0] SIZE_NONE = 8'h00;
  // decoded command field holds at most this many bytes
  localparam int FIELD_MAX = 32;
  localparam logic [5:0] FIELD_MAX_CNT = 6'h20;
  localparam logic [5:0] READ_LEN = 6'h01;
  // reply shapes
  localparam logic [1:0] REPLY_SHORT = 2'h1;
  localparam logic [1:0] REPLY_READ = 2'h3;
  // escape run state
  localparam logic [1:0] ESC_NONE = 2'h0;
  localparam logic [1:0] ESC_ONE = 2'h1;
  localparam logic [1:0] ESC_TWO = 2'h2;
  // response fifo shape
  localparam int BYTE_W = 8;
  localparam int TX_FIFO_DEPTH = 4;
  // serial line defaults of the uart around this block
  localparam int UART_BAUD = 9600;
  localparam int CLOCK_HZ = 25000000;

  // one access to the register store
  typedef struct packed {
    logic write;
    logic commit;
    logic [7:0] addr;
    logic [7:0] data;
  } ercd_req_t;

  // answer of the register store
  typedef struct packed {
    logic ok;
    logic [7:0] data;
  } ercd_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SIZE, ST_FIELD, ST_CHECK, ST_COMMIT, ST_REPLY
  } ercd_state_t;
endpackage

//--- logic/ercd_decoder.sv
// escaped register command decoder with its response byte fifo

// shift register fifo; outputs come straight from flops
module ercd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstN,
  // filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push;
  logic pop;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // occupancy next value
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + CW'(1);
    end else if (pop && !push) begin
      count_d = count_q - CW'(1);
    end
  end
  // flags registered so the top outputs stay flop driven
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      count_q <= '0;
      outValid <= 1'b0;
      inReady <= 1'b1;
    end else begin
      count_q <= count_d;
      outValid <= count_d != '0;
      inReady <= count_d != CW'(DEPTH);
    end
  end
  // entry 0 is the head; a pop shifts everything one place down
  for (genvar i = 0; i < DEPTH; i++) begin : gEntry
    always_ff @(posedge clock) begin
      if (pop) begin
        if (push && CW'(i) == count_q - CW'(1)) begin
          mem_q[i] <= inData;
        end else if (i < DEPTH - 1) begin
          mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
        end
      end else if (push && CW'(i) == count_q) begin
        mem_q[i] <= inData;
      end
    end
  end
  assign outData = mem_q[0];
endmodule

module ercd_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bytes from the uart receiver, same clock
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  // register store
  output ercd_pkg::ercd_req_t storeReq,
  output logic storeReqValid,
  input wire ercd_pkg::ercd_rsp_t storeRsp,
  input wire logic storeRspValid,
  // reply bytes to the uart transmitter
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady
);
  import ercd_pkg::*;
  logic [1:0] rstPipe_q;
  logic rstSyncN;
  ercd_state_t state_q;
  logic [1:0] escCnt_q;
  logic [1:0] escCnt_d;
  logic [5:0] decCnt_q;
  logic ovf_q;
  logic [7:0] remaining_q;
  logic [7:0] lastDec_q;
  logic [7:0] fieldMem_q [FIELD_MAX];
  logic [5:0] fieldLen_q;
  logic [4:0] idx_q;
  logic [7:0] replyBuf_q [3]; // written before every reply, so left out of reset
  logic [1:0] replyLen_q;
  logic [1:0] replyIdx_q;
  logic wroteAny_q;
  logic emitByte;
  logic [7:0] decByte;
  logic isHdr;
  logic frameEnd;
  logic goodEnd;
  logic isWrite;
  logic lastIdx;
  logic pushValid;
  logic pushReady;
  logic [7:0] pushData;
  // reset released through two flops so all flops leave reset together
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_q <= 2'b00;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_q[1];
  // headers are honoured only while receiving; during execution bytes are dropped
  assign isHdr = rxValid && rxData == HDR_BYTE && state_q inside {ST_IDLE, ST_SIZE, ST_FIELD};
  assign frameEnd = state_q == ST_FIELD && rxValid && !isHdr && remaining_q == 8'h01;
  // a dangling escape or an oversize field is malformed and gets no reply
  assign goodEnd = frameEnd && emitByte && !ovf_q && decCnt_q != FIELD_MAX_CNT;
  assign isWrite = fieldLen_q != READ_LEN;
  assign lastIdx = {1'b0, idx_q} == fieldLen_q - 6'h01;
  // byte unescaping; a third escape in a row starts a fresh run
  always_comb begin
    emitByte = 1'b0;
    decByte = rxData;
    escCnt_d = escCnt_q;
    if (state_q == ST_FIELD && rxValid && !isHdr) begin
      if (rxData == ESC_BYTE) begin
        escCnt_d = (escCnt_q == ESC_TWO) ? ESC_ONE : escCnt_q + ESC_ONE;
      end else begin
        emitByte = 1'b1;
        escCnt_d = ESC_NONE;
        case (escCnt_q)
          ESC_ONE: decByte = rxData ^ BIT7_MASK;
          ESC_TWO: decByte = (rxData >= RSV_LOW) ? rxData ^ BIT7_MASK : rxData;
          default: decByte = rxData;
        endcase
      end
    end
  end
  // field counters; escape run, decoded count and overflow flag cleared by every header
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      escCnt_q <= ESC_NONE;
      decCnt_q <= '0;
      ovf_q <= 1'b0;
      remaining_q <= '0;
      lastDec_q <= '0;
    end else if (isHdr) begin
      escCnt_q <= ESC_NONE;
      decCnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (state_q == ST_SIZE && rxValid) begin
      remaining_q <= rxData;
    end else if (state_q == ST_FIELD && rxValid) begin
      escCnt_q <= escCnt_d;
      remaining_q <= remaining_q - 8'h01;
      if (emitByte) begin
        lastDec_q <= decByte;
        if (decCnt_q == FIELD_MAX_CNT) begin
          ovf_q <= 1'b1;
        end else begin
          decCnt_q <= decCnt_q + 6'h01;
        end
      end
    end
  end
  // decoded field bytes; nothing reaches the store until the field ends
  always_ff @(posedge clock) begin
    if (emitByte && decCnt_q != FIELD_MAX_CNT) begin
      fieldMem_q[decCnt_q[4:0]] <= decByte;
    end
  end

  // frame sequencing, store accesses and reply building
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_q <= ST_IDLE;
      fieldLen_q <= '0;
      idx_q <= '0;
      storeReqValid <= 1'b0;
      storeReq <= '0;
      replyLen_q <= '0;
      replyIdx_q <= '0;
      wroteAny_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (isHdr) begin
            state_q <= ST_SIZE;
            wroteAny_q <= 1'b0;
          end
        end
        ST_SIZE: begin
          if (rxValid && !isHdr) begin
            state_q <= (rxData == SIZE_NONE) ? ST_IDLE : ST_FIELD;
          end
        end
        ST_FIELD: begin
          if (isHdr) begin
            state_q <= ST_SIZE;
            wroteAny_q <= 1'b0;
          end else if (frameEnd) begin
            state_q <= goodEnd ? ST_CHECK : ST_IDLE;
            fieldLen_q <= decCnt_q + 6'h01;
            idx_q <= (decCnt_q == '0) ? 5'h00 : 5'h01;
          end
        end
        ST_CHECK, ST_COMMIT: begin
          if (!storeReqValid) begin
            storeReqValid <= 1'b1;
            storeReq.write <= isWrite;
            storeReq.commit <= state_q == ST_COMMIT;
            storeReq.addr <= isWrite ? 8'(fieldMem_q[0] + {3'h0, idx_q} - 8'h01) : fieldMem_q[0] ^ BIT7_MASK;
            storeReq.data <= fieldMem_q[idx_q];
          end else if (storeRspValid) begin
            storeReqValid <= 1'b0;
            if (state_q == ST_COMMIT) begin
              wroteAny_q <= 1'b1;
            end
            if (state_q == ST_CHECK && !storeRsp.ok) begin
              replyBuf_q[0] <= NACK_BYTE;
              replyLen_q <= REPLY_SHORT;
              state_q <= ST_REPLY;
            end else if (!isWrite) begin
              replyBuf_q[0] <= ACK_BYTE;
              replyBuf_q[1] <= storeReq.addr;
              replyBuf_q[2] <= storeRsp.data;
              replyLen_q <= REPLY_READ;
              state_q <= ST_REPLY;
            end else if (!lastIdx) begin
              idx_q <= idx_q + 5'h01;
            end else if (state_q == ST_CHECK) begin
              // every target proved writable before the first commit
              idx_q <= 5'h01;
              state_q <= ST_COMMIT;
            end else begin
              replyBuf_q[0] <= ACK_BYTE;
              replyLen_q <= REPLY_SHORT;
              state_q <= ST_REPLY;
            end
          end
        end
        ST_REPLY: begin
          // a full fifo stalls the reply here
          if (pushReady) begin
            if (replyIdx_q == replyLen_q - 2'h1) begin
              replyIdx_q <= '0;
              state_q <= ST_IDLE;
            end else begin
              replyIdx_q <= replyIdx_q + 2'h1;
            end
          end
        end
      endcase
    end
  end

  assign pushValid = state_q == ST_REPLY;
  assign pushData = replyBuf_q[replyIdx_q];

  ercd_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) uTxFifo (
    .clock(clock),
    .rstN(rstSyncN),
    .inValid(pushValid),
    .inData(pushData),
    .inReady(pushReady),
    .outValid(txValid),
    .outData(txData),
    .outReady(txReady)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSyncN);

  chk_escape_toggle: assert property (
    state_q == ST_FIELD && rxValid && !isHdr && escCnt_q == ESC_ONE && rxData != ESC_BYTE
    |=> lastDec_q == ($past(rxData) ^ BIT7_MASK)) else $error("escaped byte not toggled");
  chk_double_cancel: assert property (
    state_q == ST_FIELD && rxValid && escCnt_q == ESC_TWO && rxData < RSV_LOW
    |=> lastDec_q == $past(rxData)) else $error("double escape did not cancel");
  chk_literal_byte: assert property (
    state_q == ST_FIELD && rxValid && escCnt_q == ESC_NONE && rxData <= LIT_MAX
    |=> lastDec_q == $past(rxData)) else $error("literal byte altered");
  chk_header_restart: assert property (
    isHdr |=> state_q == ST_SIZE && decCnt_q == '0) else $error("header did not restart frame");
  chk_size_ends: assert property (
    frameEnd |=> state_q != ST_FIELD) else $error("frame outlived its size");
  chk_read_addr: assert property (
    $rose(storeReqValid) && !storeReq.write |-> storeReq.addr == (fieldMem_q[0] ^ BIT7_MASK))
    else $error("read register not bit 7 inverted");
  chk_read_reply: assert property (
    state_q == ST_CHECK && storeReqValid && storeRspValid && !storeReq.write && storeRsp.ok
    |=> replyLen_q == REPLY_READ && replyBuf_q[0] == ACK_BYTE && replyBuf_q[2] == $past(storeRsp.data))
    else $error("read reply malformed");
  chk_nack_reply: assert property (
    state_q == ST_CHECK && storeReqValid && storeRspValid && !storeRsp.ok
    |=> state_q == ST_REPLY && replyLen_q == REPLY_SHORT && replyBuf_q[0] == NACK_BYTE)
    else $error("failed check not nacked");
  chk_write_ack: assert property (
    state_q == ST_COMMIT && storeReqValid && storeRspValid && lastIdx
    |=> state_q == ST_REPLY && replyBuf_q[0] == ACK_BYTE) else $error("write not acknowledged");
  chk_nack_no_write: assert property (
    pushValid && pushData == NACK_BYTE |-> !wroteAny_q) else $error("nack after a committed write");
  chk_reply_stall: assert property (
    pushValid && !pushReady |=> pushValid && $stable(pushData)) else $error("reply lost under back-pressure");

  cov_read_ack: cover property (pushValid && pushReady && replyLen_q == REPLY_READ);
  cov_write_ack: cover property (state_q == ST_COMMIT ##1 state_q == ST_REPLY);
  cov_nack: cover property (pushValid && pushData == NACK_BYTE);
  cov_restart: cover property (state_q == ST_FIELD && isHdr);
endmodule

//--- sim/ercd_store_model.sv
// register store model that answers the decoder's check and commit accesses
module ercd_store_model #(
  parameter logic [7:0] RO_BASE = 8'hf0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstN,
  // answer pace
  input wire logic slow,
  // access port
  input wire ercd_pkg::ercd_req_t storeReq,
  input wire logic storeReqValid,
  output ercd_pkg::ercd_rsp_t storeRsp,
  output logic storeRspValid
);
  import ercd_pkg::*;
  logic [7:0] mem [256];
  logic [255:0] wrQ;
  logic [1:0] waitQ;
  logic doneQ;
  logic okNow;
  // places from RO_BASE up refuse reads and writes alike, standing for read-only or missing registers
  assign okNow = storeReq.addr < RO_BASE;
  // an unwritten place reads as the inverse of its address, so no init block is needed
  function automatic logic [7:0] peek(input logic [7:0] a);
    return wrQ[a] ? mem[a] : ~a;
  endfunction
  // one answer per access; a released data bus shows the inverse of its last value
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      waitQ <= 2'h0;
      doneQ <= 1'b0;
      wrQ <= '0;
      storeRspValid <= 1'b0;
      storeRsp <= '0;
    end else begin
      storeRspValid <= 1'b0;
      storeRsp.data <= ~storeRsp.data;
      if (!storeReqValid) begin
        waitQ <= 2'h0;
        doneQ <= 1'b0;
      end else if (!doneQ && waitQ == (slow ? 2'h2 : 2'h0)) begin
        storeRspValid <= 1'b1;
        storeRsp.ok <= okNow;
        storeRsp.data <= peek(storeReq.addr);
        doneQ <= 1'b1;
        // only a commit access may change contents
        if (storeReq.commit && okNow) begin
          mem[storeReq.addr] <= storeReq.data;
          wrQ[storeReq.addr] <= 1'b1;
        end
      end else if (!doneQ) begin
        waitQ <= waitQ + 2'h1;
      end
    end
  end
endmodule

//--- sim/ercd_decoder_bench.sv
// self-checking bench of the escaped register command decoder
module ercd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ercd_pkg::*;
  typedef logic [7:0] ercd_bytes_t [$];
  logic clock;
  logic rst_n;
  logic rxValid;
  logic [7:0] rxData;
  ercd_req_t storeReq;
  logic storeReqValid;
  ercd_rsp_t storeRsp;
  logic storeRspValid;
  logic txValid;
  logic [7:0] txData;
  logic txReady;
  logic slow;
  int bad_count;
  int cmp_count;

  ercd_decoder i_dut (
    .clock(clock),
    .rst_n(rst_n),
    .rxValid(rxValid),
    .rxData(rxData),
    .storeReq(storeReq),
    .storeReqValid(storeReqValid),
    .storeRsp(storeRsp),
    .storeRspValid(storeRspValid),
    .txValid(txValid),
    .txData(txData),
    .txReady(txReady)
  );

  ercd_store_model i_store (
    .clock(clock),
    .rstN(rst_n),
    .slow(slow),
    .storeReq(storeReq),
    .storeReqValid(storeReqValid),
    .storeRsp(storeRsp),
    .storeRspValid(storeRspValid)
  );

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  // bytes go back to back, one per cycle; the idle bus shows the inverse byte
  task automatic send(input ercd_bytes_t b);
    foreach (b[i]) begin
      rxValid = 1'b1;
      rxData = b[i];
      @(negedge clock);
    end
    rxValid = 1'b0;
    rxData = ~rxData;
  endtask

  // fixed window long enough for the slowest reply, so extra bytes are caught too;
  // with gap set the transmitter takes a byte only every other cycle
  task automatic reply(input ercd_bytes_t exp, input logic gap);
    int n;
    n = 0;
    repeat (300) begin
      txReady = gap ? ~txReady : 1'b1;
      if (txValid === 1'b1 && txReady === 1'b1) begin
        if (n < exp.size()) begin
          check(txData, exp[n]);
        end else begin
          bad_count++;
          $display("ERROR %0t extra reply byte %h", $time, txData);
        end
        n++;
      end
      @(negedge clock);
    end
    if (n < exp.size()) begin
      bad_count++;
      $display("ERROR %0t reply short by %0d bytes", $time, exp.size() - n);
      wrap_up();
    end
  endtask

  task automatic xact(input ercd_bytes_t frm, input ercd_bytes_t exp);
    send(frm);
    reply(exp, 1'b0);
  endtask

  task automatic t_plain();
    xact('{8'hff, 8'h02, 8'h10, 8'h33}, '{ACK_BYTE});
    xact('{8'hff, 8'h01, 8'h90}, '{ACK_BYTE, 8'h10, 8'h33});
    xact('{8'hff, 8'h02, 8'h1a, 8'hc0}, '{ACK_BYTE});
    xact('{8'hff, 8'h01, 8'h9a}, '{ACK_BYTE, 8'h1a, 8'hc0});
  endtask

  task automatic t_escape();
    xact('{8'hff, 8'h04, 8'hfe, 8'h03, 8'hfe, 8'h7f}, '{ACK_BYTE});
    check(i_store.peek(8'h83), 8'hff);
    xact('{8'hff, 8'h01, 8'h03}, '{ACK_BYTE, 8'h83, 8'hff});
    xact('{8'hff, 8'h02, 8'hfe, 8'h03}, '{ACK_BYTE, 8'h03, 8'hfc});
  endtask

  task automatic t_double();
    xact('{8'hff, 8'h03, 8'hfe, 8'hfe, 8'h53}, '{ACK_BYTE, 8'hd3, 8'h2c});
    // a cancelled pair here would read register 0x73 and answer with an ack
    xact('{8'hff, 8'h03, 8'hfe, 8'hfe, 8'hf3}, '{NACK_BYTE});
  endtask

  task automatic t_nack();
    xact('{8'hff, 8'h03, 8'hfe, 8'h75, 8'h01}, '{NACK_BYTE});
    check(i_store.peek(8'hf5), 8'h0a);
    xact('{8'hff, 8'h04, 8'hef, 8'h11, 8'h22, 8'h33}, '{NACK_BYTE});
    check(i_store.peek(8'hef), 8'h10);
  endtask

  task automatic t_multi();
    xact('{8'hff, 8'h04, 8'h20, 8'h01, 8'h02, 8'h03}, '{ACK_BYTE});
    check(i_store.peek(8'h22), 8'h03);
    xact('{8'hff, 8'h01, 8'ha1}, '{ACK_BYTE, 8'h21, 8'h02});
  endtask

  task automatic t_abort();
    xact('{8'hff, 8'h03, 8'h10, 8'hff, 8'h02, 8'h11, 8'h44}, '{ACK_BYTE});
    check(i_store.peek(8'h10), 8'h33);
    check(i_store.peek(8'h11), 8'h44);
  endtask

  task automatic t_refuse();
    ercd_bytes_t frm;
    frm = '{8'hff, 8'h21};
    repeat (33) frm.push_back(8'h01);
    xact('{8'hff, 8'h00}, '{});
    xact('{8'hff, 8'h02, 8'h10, 8'hfe}, '{});
    xact(frm, '{});
    check(i_store.peek(8'h01), 8'hfe);
  endtask

  // two replies pile up behind a stalled transmitter and fill the 4-byte fifo; draining is paced
  task automatic t_fifo();
    slow = 1'b1;
    txReady = 1'b0;
    send('{8'hff, 8'h01, 8'h90});
    repeat (30) @(negedge clock);
    send('{8'hff, 8'h01, 8'ha0});
    repeat (30) @(negedge clock);
    reply('{ACK_BYTE, 8'h10, 8'h33, ACK_BYTE, 8'h20, 8'h01}, 1'b1);
    slow = 1'b0;
  endtask

  // a reset cuts a write in flight; the host sees no acknowledge and sends it again
  task automatic t_retry();
    send('{8'hff, 8'h03, 8'h30});
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    check({7'h00, txValid}, 8'h00);
    check({7'h00, storeReqValid}, 8'h00);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    reply('{}, 1'b0);
    xact('{8'hff, 8'h03, 8'h30, 8'hfe, 8'h55}, '{ACK_BYTE});
    check(i_store.peek(8'h30), 8'hd5);
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
    slow = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_plain();
    t_escape();
    t_double();
    t_nack();
    t_multi();
    t_abort();
    t_refuse();
    t_fifo();
    t_retry();
    wrap_up();
  end
endmodule
